// *** pfr_regs.sv ***
// Programmable CPU frequency control bytes and source selection.
// Assumes the serial bus front end presents single-cycle byte writes and
// reads, and that strap pins are stable around the release of reset.
// Notes on behaviour
// - enable set means CPU frequency comes from N and M values.
// - writing M starts loading a new frequency; N alone does not.
// - override clear selects ratio from straps latched after each reset.
// - override set selects ratio from software select code.
// - enable is M byte bit 7; enable, N and M reset to zero.
// - disabled mode picks operating frequency from straps or select code.
// - enabled mode uses N, M and gear chosen by the selected code.
`timescale 1ns/1ps
`default_nettype none
module pfr_regs (
    input wire logic clock,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    input wire logic [4:0] strap_pins,
    input wire logic strap_code_override,
    input wire logic [4:0] sw_sel_code,
    output logic prog_freq_enable,
    output logic [7:0] cpu_n_field,
    output logic [6:0] cpu_m_field,
    output logic [4:0] active_sel_code,
    output logic freq_load,
    output logic [4:0] latched_strap_code,
    output logic [2:0] vendor_test_bits
);
    typedef struct packed {
        pfr_pkg::pfr_state_t state;
        logic strap_taken;
        logic [4:0] strap;
        logic [7:0] n;
        logic [6:0] m;
        logic en;
        logic [2:0] vtest;
        logic [4:0] sel;
        logic load;
        logic [7:0] rdata;
    } pfr_regs_t;

    pfr_regs_t s_q;
    pfr_regs_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.load = 1'b0;
        s_d.state = pfr_pkg::PFR_IDLE;
        // ---------------------------------------------------------------
        // Strap capture
        // ---------------------------------------------------------------
        // Taken on the first clock after reset; later pin changes ignored
        if (!s_q.strap_taken) begin
            s_d.strap = strap_pins;
            s_d.strap_taken = 1'b1;
        end
        // ---------------------------------------------------------------
        // Register writes
        // ---------------------------------------------------------------
        if (wr_en) begin
            case (addr)
                pfr_pkg::OFS_N_VALUE: begin
                    s_d.n = wr_data;
                end
                pfr_pkg::OFS_M_VALUE: begin
                    s_d.m = wr_data[6:0];
                    s_d.en = wr_data[pfr_pkg::EN_BIT];
                    s_d.load = 1'b1;
                    s_d.state = pfr_pkg::PFR_LOAD;
                end
                pfr_pkg::OFS_VENDOR_TEST: begin
                    // Bits 2:0 stored as written; the host owns the test values
                    s_d.vtest = wr_data[2:0];
                end
                default: begin
                end
            endcase
        end
        // ---------------------------------------------------------------
        // Source selection
        // ---------------------------------------------------------------
        if (strap_code_override) begin
            s_d.sel = sw_sel_code;
        end else begin
            s_d.sel = s_d.strap;
        end
        // ---------------------------------------------------------------
        // Read data
        // ---------------------------------------------------------------
        s_d.rdata = s_q.rdata;
        if (rd_en) begin
            case (addr)
                pfr_pkg::OFS_N_VALUE: s_d.rdata = s_q.n;
                pfr_pkg::OFS_M_VALUE: s_d.rdata = {s_q.en, s_q.m};
                pfr_pkg::OFS_VENDOR_TEST: s_d.rdata = {5'h00, s_q.vtest};
                default: s_d.rdata = pfr_pkg::READ_ZERO;
            endcase
        end
        if (reset) begin
            s_d.state = pfr_pkg::PFR_IDLE;
            s_d.strap_taken = 1'b0;
            s_d.strap = pfr_pkg::RST_STRAP;
            s_d.n = pfr_pkg::RST_N_VALUE;
            s_d.m = pfr_pkg::RST_M_VALUE;
            s_d.en = pfr_pkg::RST_ENABLE;
            s_d.vtest = pfr_pkg::RST_VENDOR_TEST;
            s_d.sel = pfr_pkg::RST_SEL;
            s_d.load = 1'b0;
            s_d.rdata = pfr_pkg::READ_ZERO;
        end
    end

    always_ff @(posedge clock) begin
        s_q <= s_d;
    end

    assign rd_data = s_q.rdata;
    assign prog_freq_enable = s_q.en;
    assign cpu_n_field = s_q.n;
    assign cpu_m_field = s_q.m;
    assign active_sel_code = s_q.sel;
    assign freq_load = s_q.load;
    assign latched_strap_code = s_q.strap;
    assign vendor_test_bits = s_q.vtest;
endmodule
`default_nettype wire

// *** pfr_pkg.sv ***
// Package for the programmable CPU frequency register block.
// Assumes a byte-wide register port driven by a serial bus front end.
package pfr_pkg;
    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_N_VALUE = 8'h0D;
    localparam logic [7:0] OFS_M_VALUE = 8'h0E;
    localparam logic [7:0] OFS_VENDOR_TEST = 8'h0F;
    localparam logic [7:0] OFS_SPARE = 8'h10;
    // ---------------------------------------------------------------
    // Fields and reset values
    // ---------------------------------------------------------------
    localparam int EN_BIT = 7;
    localparam logic [7:0] RST_N_VALUE = 8'h00;
    localparam logic [6:0] RST_M_VALUE = 7'h00;
    localparam logic RST_ENABLE = 1'b0;
    localparam logic [2:0] RST_VENDOR_TEST = 3'h3;
    localparam logic [4:0] RST_SEL = 5'h00;
    localparam logic [4:0] RST_STRAP = 5'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // Supported programmed CPU window, MHz (host's duty)
    localparam int FREQ_MIN_MHZ = 50;
    localparam int FREQ_MAX_MHZ = 248;
    typedef enum {PFR_IDLE, PFR_LOAD} pfr_state_t;
endpackage

// *** pfr_regs_sva.sv ***
// Checker for pfr_regs, bound from this file.
// Sees only the block's ports.
`timescale 1ns/1ps
`default_nettype none
module pfr_regs_sva (input wire logic clock, reset, wr_en, rd_en, strap_code_override,
    input wire logic [7:0] addr, wr_data, rd_data, cpu_n_field,
    input wire logic [6:0] cpu_m_field,
    input wire logic prog_freq_enable, freq_load,
    input wire logic [4:0] sw_sel_code, latched_strap_code, active_sel_code);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence m_wr;
        wr_en && addr == 8'h0E;
    endsequence
    load_on_m_a: assert property (m_wr |=> freq_load) else $error("no load");
    load_cause_a: assert property (freq_load |-> $past(wr_en && addr == 8'h0E))
        else $error("stray load");
    m_take_a: assert property (m_wr |=> {prog_freq_enable, cpu_m_field} == $past(wr_data))
        else $error("m lost");
    n_take_a: assert property (wr_en && addr == 8'h0D |=> cpu_n_field == $past(wr_data))
        else $error("n lost");
    n_keep_a: assert property (!(wr_en && addr == 8'h0D) |=> $stable(cpu_n_field))
        else $error("n moved");
    // Straps and select move together on the capture edge, so compare same-cycle values
    strap_sel_a: assert property (!strap_code_override |=>
        active_sel_code == latched_strap_code) else $error("strap sel");
    sw_sel_a: assert property (strap_code_override |=>
        active_sel_code == $past(sw_sel_code)) else $error("sw sel");
    spare_zero_a: assert property (rd_en && addr == 8'h10 |=> rd_data == 8'h00)
        else $error("spare read");
    reset_val_a: assert property ($fell(reset) |->
        {prog_freq_enable, cpu_m_field, cpu_n_field} == 15'h0000) else $error("reset vals");
endmodule
bind pfr_regs pfr_regs_sva chk_u (.*);
`default_nettype wire

// *** pfr_host.sv ***
// Bus host model: one byte transfer per call.
// Assumes strobes are sampled on rising edges.
`timescale 1ns/1ps
`default_nettype none
module pfr_host (input wire logic clock, output logic wr_en, rd_en,
    output logic [7:0] addr, wr_data);
    initial {wr_en, rd_en, addr, wr_data} = 18'h00000;
    task automatic xfer(input logic w, input logic [7:0] a, d);
        @(posedge clock);
        {wr_en, rd_en, addr, wr_data} <= {w, !w, a, d};
        @(posedge clock);
        // Released bus shows inverse, not stale values
        {wr_en, rd_en, addr, wr_data} <= {2'h0, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// *** test_pfr_regs.sv ***
// Testbench for pfr_regs; reads scored in order from a queue.
// Assumes the checker binds itself.
`timescale 1ns/1ps
`default_nettype none
module test_pfr_regs;
    logic clock = 0, reset = 1, strap_code_override = 0, rd_d = 0;
    logic [4:0] strap_pins, sw_sel_code, active_sel_code, latched_strap_code;
    logic wr_en, rd_en, prog_freq_enable, freq_load;
    logic [7:0] addr, wr_data, rd_data, cpu_n_field, v, exp_q[$];
    logic [6:0] cpu_m_field;
    logic [2:0] vendor_test_bits;
    int mismatches = 0, compares = 0, cyc = 0;
    pfr_regs dut_u (.*);
    pfr_host host_u (.*);
    initial forever #50 clock = ~clock;
    task check(string nm, logic [7:0] s, e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s exp %h seen %h", nm, e, s);
        end
    endtask
    task rd(logic [7:0] a, e);
        exp_q.push_back(e);
        host_u.xfer(1'b0, a, 8'h00);
    endtask
    task end_of_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clock) rd_d <= rd_en;
    always @(negedge clock) if (rd_d) check("rd_data", rd_data, exp_q.pop_front());
    always @(posedge clock) if (++cyc == 500) begin
        mismatches++;
        end_of_test();
    end
    initial begin
        v = 8'($urandom(32'h8eb041f1));
        strap_pins = 5'($urandom);
        sw_sel_code = ~strap_pins;
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        rd(8'h0E, 8'h00);
        check("vtest", 8'(vendor_test_bits), 8'h03);
        check("strap", 8'(latched_strap_code), 8'(strap_pins));
        host_u.xfer(1'b1, 8'h0D, v);
        @(negedge clock) check("freq_load", 8'(freq_load), 8'h00);
        host_u.xfer(1'b1, 8'h0E, {1'b1, v[6:0]});
        @(negedge clock) check("freq_load", 8'(freq_load), 8'h01);
        check("n_field", cpu_n_field, v);
        check("m_field", 8'(cpu_m_field), 8'(v[6:0]));
        check("enable", 8'(prog_freq_enable), 8'h01);
        rd(8'h0D, v);
        rd(8'h0E, {1'b1, v[6:0]});
        $display("test program done");
        @(posedge clock) strap_code_override <= 1'b1;
        repeat (2) @(negedge clock);
        check("active_sel", 8'(active_sel_code), 8'(sw_sel_code));
        @(posedge clock) strap_code_override <= 1'b0;
        repeat (2) @(negedge clock);
        check("active_sel", 8'(active_sel_code), 8'(strap_pins));
        host_u.xfer(1'b1, 8'h0F, 8'hFB);
        host_u.xfer(1'b1, 8'h10, 8'hFF);
        rd(8'h0F, 8'h03);
        rd(8'h10, 8'h00);
        rd(8'h55, 8'h00);
        repeat (2) @(posedge clock);
        check("vtest", 8'(vendor_test_bits), 8'h03);
        $display("test reserved done");
        @(posedge clock) reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        rd(8'h0E, 8'h00);
        check("n_field", cpu_n_field, 8'h00);
        check("enable", 8'(prog_freq_enable), 8'h00);
        check("strap", 8'(latched_strap_code), 8'(strap_pins));
        repeat (2) @(posedge clock);
        $display("test reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
